/* verilog/vss_regs.sv */
// Purpose: video sync status and control register bank on an AXI4-Lite slave
// Assumes: front-end status arrives from another domain and is synchronised here
// Notes: one write and one read in flight; unmapped words answer SLVERR
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module vss_regs #(
   parameter int FW_REVISION = 8'h01,  // arbitrary value
   parameter int FW_RELEASE  = 4'h1    // arbitrary value
) (
   // clock and reset
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // axi4-lite write address
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [vss_pkg::VSS_AW-1:0]  awaddr,
   input  wire logic [2:0]                  awprot,
   // axi4-lite write data
   input  wire logic                        wvalid,
   output logic                             wready,
   input  wire logic [vss_pkg::VSS_DW-1:0]  wdata,
   input  wire logic [3:0]                  wstrb,
   // axi4-lite write response
   output logic                             bvalid,
   input  wire logic                        bready,
   output logic [1:0]                       bresp,
   // axi4-lite read address
   input  wire logic                        arvalid,
   output logic                             arready,
   input  wire logic [vss_pkg::VSS_AW-1:0]  araddr,
   input  wire logic [2:0]                  arprot,
   // axi4-lite read data
   output logic                             rvalid,
   input  wire logic                        rready,
   output logic [vss_pkg::VSS_DW-1:0]       rdata,
   output logic [1:0]                       rresp,
   // front-end recognition levels
   input  wire logic [vss_pkg::ST_W-1:0]    std_flags,
   input  wire logic                        std_525,
   input  wire logic                        field_toggle,
   input  wire logic [vss_pkg::VSS_RW-1:0]  line_number,
   input  wire logic                        agc_pulse_seen,
   input  wire logic                        pseudo_sync_seen,
   input  wire logic [vss_pkg::VSS_RW-1:0]  sync_amp_in,
   input  wire logic [vss_pkg::VSS_RW-1:0]  burst_amp_in,
   // controls to the firmware processor
   output logic                             autolock_enable,
   output logic [vss_pkg::VSS_RW-1:0]       autolock_threshold,
   output logic                             vertical_force,
   output logic                             flywheel_disable,
   output logic                             vertical_free_run,
   // interrupt
   output logic                             irq
);
   import vss_pkg::*;

   if (FW_REVISION < 0 || FW_REVISION >= (1 << FW_REV_W)) begin : g_chk_rev
      $error("FW_REVISION does not fit its field");
   end
   if (FW_RELEASE < 0 || FW_RELEASE >= (1 << FW_REL_W)) begin : g_chk_rel
      $error("FW_RELEASE does not fit its field");
   end

   localparam int SYW = ST_W + 1 + 1 + VSS_RW + 2 + VSS_RW + VSS_RW;

   // word index of a byte address; low two bits ignored
   function automatic logic [VSS_IW-1:0] word_idx(input logic [VSS_AW-1:0] a);
      return a[VSS_AW-1:2];
   endfunction

   // is this word index one of the mapped registers
   function automatic logic idx_mapped(input logic [VSS_IW-1:0] i);
      case (i)
         IDX_GEN_CTRL, IDX_STD_STATUS, IDX_FIELD_CNT, IDX_BURST_AMP,
         IDX_SYNC_AMP, IDX_AUTOLOCK, IDX_LINES_PF, IDX_FW_REV,
         IDX_CP_STATUS, IDX_CP_FIRST, IDX_CP_LAST, IDX_IRQ_STATUS,
         IDX_IRQ_MASK: return 1'b1;
         default:      return 1'b0;
      endcase
   endfunction

   // byte-lane merge of a 12-bit register with the write data
   function automatic logic [VSS_RW-1:0] merge12(input logic [VSS_RW-1:0] old,
                                                 input logic [VSS_DW-1:0] d,
                                                 input logic [3:0]        s);
      logic [VSS_RW-1:0] r;
      r = old;
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[11:8] = d[11:8];
      end
      return r;
   endfunction

   // synchronised front-end levels
   logic [SYW-1:0]    sync_vec;
   logic [ST_W-1:0]   st_s;
   logic              std525_s;
   logic              field_s;
   logic [VSS_RW-1:0] line_s;
   logic              agc_s;
   logic              psync_s;
   logic [VSS_RW-1:0] samp_s;
   logic [VSS_RW-1:0] bamp_s;

   vss_sync #(
      .W        (SYW)
   ) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in ({std_flags, std_525, field_toggle, line_number,
                  agc_pulse_seen, pseudo_sync_seen, sync_amp_in, burst_amp_in}),
      .sync_out (sync_vec)
   );

   // measurements are slow-moving, so a torn word is at worst one sample off
   assign {st_s, std525_s, field_s, line_s, agc_s, psync_s, samp_s, bamp_s} = sync_vec;

   // register state
   logic [VSS_RW-1:0] autolock_ff;
   logic [VSS_RW-1:0] gen_ctrl_ff;
   logic [VSS_RW-1:0] field_cnt_ff;
   logic [VSS_RW-1:0] cp_first_ff;
   logic [VSS_RW-1:0] cp_last_ff;
   logic [ST_W-1:0]   std_status_ff;
   logic [VSS_RW-1:0] lines_pf_ff;
   logic [VSS_RW-1:0] sync_amp_ff;
   logic [VSS_RW-1:0] burst_amp_ff;
   logic [CP_W-1:0]   cp_acc_ff;
   logic [CP_W-1:0]   cp_status_ff;
   logic              field_d_ff;
   logic [IRQ_W-1:0]  irq_status_ff;
   logic [IRQ_W-1:0]  irq_mask_ff;
   logic              irq_ff;

   // bus state
   logic              awready_ff;
   logic              wready_ff;
   logic              aw_held_ff;
   logic              w_held_ff;
   logic [VSS_AW-1:0] aw_addr_ff;
   logic [VSS_DW-1:0] w_data_ff;
   logic [3:0]        w_strb_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              arready_ff;
   logic              rvalid_ff;
   logic [VSS_DW-1:0] rdata_ff;
   logic [1:0]        rresp_ff;

   // decoded strobes
   logic              do_write;
   logic [VSS_IW-1:0] w_idx;
   logic              rd_take;
   logic [VSS_IW-1:0] r_idx;
   logic              field_tick;
   logic              in_window;
   logic [CP_W-1:0]   cp_hit;
   logic [IRQ_W-1:0]  irq_events;
   logic [VSS_RW-1:0] rd_word;

   assign do_write   = aw_held_ff & w_held_ff & ~bvalid_ff;
   assign w_idx      = word_idx(aw_addr_ff);
   assign rd_take    = arvalid & arready_ff;
   assign r_idx      = word_idx(araddr);
   assign field_tick = field_s ^ field_d_ff;

   // ---------------- write channels ----------------
   // address and data are taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b0;
         aw_held_ff <= 1'b0;
         aw_addr_ff <= '0;
      end else if (awvalid && awready_ff) begin
         awready_ff <= 1'b0;
         aw_held_ff <= 1'b1;
         aw_addr_ff <= awaddr;
      end else if (do_write) begin
         aw_held_ff <= 1'b0;
      end else if (!aw_held_ff && !bvalid_ff) begin
         awready_ff <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_ff <= 1'b0;
         w_held_ff <= 1'b0;
         w_data_ff <= '0;
         w_strb_ff <= 4'h0;
      end else if (wvalid && wready_ff) begin
         wready_ff <= 1'b0;
         w_held_ff <= 1'b1;
         w_data_ff <= wdata;
         w_strb_ff <= wstrb;
      end else if (do_write) begin
         w_held_ff <= 1'b0;
      end else if (!w_held_ff && !bvalid_ff) begin
         wready_ff <= 1'b1;
      end
   end

   // response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= idx_mapped(w_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // ---------------- read channel ----------------
   // read-only words ignore writes; write-only threshold reads as zero
   always_comb begin
      rd_word = '0;
      case (r_idx)
         IDX_GEN_CTRL:   rd_word = gen_ctrl_ff;
         IDX_STD_STATUS: rd_word = {{(VSS_RW-ST_W){1'b0}}, std_status_ff};
         IDX_FIELD_CNT:  rd_word = field_cnt_ff;
         IDX_BURST_AMP:  rd_word = burst_amp_ff;
         IDX_SYNC_AMP:   rd_word = sync_amp_ff;
         IDX_LINES_PF:   rd_word = lines_pf_ff;
         IDX_FW_REV:     rd_word = {FW_RELEASE[FW_REL_W-1:0], FW_REVISION[FW_REV_W-1:0]};
         IDX_CP_STATUS:  rd_word = {{(VSS_RW-CP_W){1'b0}}, cp_status_ff};
         IDX_CP_FIRST:   rd_word = cp_first_ff;
         IDX_CP_LAST:    rd_word = cp_last_ff;
         IDX_IRQ_STATUS: rd_word = {{(VSS_RW-IRQ_W){1'b0}}, irq_status_ff};
         IDX_IRQ_MASK:   rd_word = {{(VSS_RW-IRQ_W){1'b0}}, irq_mask_ff};
         default:        rd_word = '0;
      endcase
   end

   // data is captured at the address handshake, so it answers one cycle later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= '0;
         rresp_ff   <= RESP_OKAY;
      end else if (rd_take) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= {{(VSS_DW-VSS_RW){1'b0}}, rd_word};
         rresp_ff   <= idx_mapped(r_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff && rready) begin
         rvalid_ff  <= 1'b0;
      end else if (!rvalid_ff) begin
         arready_ff <= 1'b1;
      end
   end

   // ---------------- control registers ----------------
   // threshold is write-only; any nonzero value arms automatic locking
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         autolock_ff <= RST_AUTOLOCK;
      end else if (do_write && w_idx == IDX_AUTOLOCK) begin
         autolock_ff <= merge12(autolock_ff, w_data_ff, w_strb_ff);
      end
   end

   // whole word is stored so reserved groups read back for read-modify-write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gen_ctrl_ff <= RST_GEN_CTRL;
      end else if (do_write && w_idx == IDX_GEN_CTRL) begin
         gen_ctrl_ff <= merge12(gen_ctrl_ff, w_data_ff, w_strb_ff);
      end
   end

   // copy-protect window limits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cp_first_ff <= RST_CP_FIRST;
         cp_last_ff  <= RST_CP_LAST;
      end else if (do_write) begin
         if (w_idx == IDX_CP_FIRST) begin
            cp_first_ff <= merge12(cp_first_ff, w_data_ff, w_strb_ff);
         end
         if (w_idx == IDX_CP_LAST) begin
            cp_last_ff <= merge12(cp_last_ff, w_data_ff, w_strb_ff);
         end
      end
   end

   // interrupt mask
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask_ff <= RST_IRQ_MASK;
      end else if (do_write && w_idx == IDX_IRQ_MASK && w_strb_ff[0]) begin
         irq_mask_ff <= w_data_ff[IRQ_W-1:0];
      end
   end

   // control outputs are registered copies of the decoded bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         autolock_enable    <= 1'b0;
         autolock_threshold <= '0;
         vertical_force     <= 1'b0;
         flywheel_disable   <= 1'b0;
         vertical_free_run  <= 1'b0;
      end else begin
         autolock_enable    <= |autolock_ff;
         autolock_threshold <= autolock_ff;
         vertical_force     <= gen_ctrl_ff[GC_VFORCE];
         flywheel_disable   <= gen_ctrl_ff[GC_DFLW];
         vertical_free_run  <= gen_ctrl_ff[GC_VFORCE] & ~gen_ctrl_ff[GC_DFLW];
      end
   end

   // ---------------- status capture ----------------
   // recognition flags, lines per field and amplitudes follow the front end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         std_status_ff <= '0;
         lines_pf_ff   <= LINES_625;
         sync_amp_ff   <= '0;
         burst_amp_ff  <= '0;
      end else begin
         std_status_ff <= st_s;
         lines_pf_ff   <= std525_s ? LINES_525 : LINES_625;
         sync_amp_ff   <= samp_s;
         burst_amp_ff  <= bamp_s;
      end
   end

   // field edge: a toggle crosses safely where a short pulse could be missed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         field_d_ff <= 1'b0;
      end else begin
         field_d_ff <= field_s;
      end
   end

   // a software write wins over a field tick in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         field_cnt_ff <= RST_FIELD_CNT;
      end else if (do_write && w_idx == IDX_FIELD_CNT) begin
         field_cnt_ff <= merge12(field_cnt_ff, w_data_ff, w_strb_ff);
      end else if (field_tick) begin
         field_cnt_ff <= field_cnt_ff + 12'h001;
      end
   end

   // ---------------- copy-protect detection ----------------
   assign in_window = (line_s >= cp_first_ff) && (line_s <= cp_last_ff);
   assign cp_hit    = {psync_s, agc_s} & {CP_W{in_window}};

   // hits gather over one field and are published at the field edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cp_acc_ff    <= '0;
         cp_status_ff <= '0;
      end else if (field_tick) begin
         cp_acc_ff    <= '0;
         cp_status_ff <= cp_acc_ff | cp_hit;
      end else begin
         cp_acc_ff    <= cp_acc_ff | cp_hit;
      end
   end

   // ---------------- interrupts ----------------
   assign irq_events[IRQ_FIELD]    = field_tick;
   assign irq_events[IRQ_CP]       = |cp_hit;
   assign irq_events[IRQ_STD_CHG]  = (st_s != std_status_ff);
   assign irq_events[IRQ_SIG_LOST] = st_s[ST_NO_SIGNAL] & ~std_status_ff[ST_NO_SIGNAL];

   // sticky bits clear on read; a new event in the clearing cycle still sets
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_ff <= '0;
      end else if (rd_take && r_idx == IDX_IRQ_STATUS) begin
         irq_status_ff <= irq_events;
      end else begin
         irq_status_ff <= irq_status_ff | irq_events;
      end
   end

   // level output, one cycle behind the status it reflects
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(irq_status_ff & irq_mask_ff);
      end
   end

   // bus outputs straight from flip-flops
   assign awready = awready_ff;
   assign wready  = wready_ff;
   assign bvalid  = bvalid_ff;
   assign bresp   = bresp_ff;
   assign arready = arready_ff;
   assign rvalid  = rvalid_ff;
   assign rdata   = rdata_ff;
   assign rresp   = rresp_ff;
   assign irq     = irq_ff;

   // protection bits carry no meaning for this bank
   logic unused_prot;
   assign unused_prot = ^{awprot, arprot, w_data_ff[VSS_DW-1:VSS_RW], w_strb_ff[3:2]};
endmodule
`default_nettype wire

/* verilog/vss_pkg.sv */
// Purpose: constants for the video sync status and control register bank
// Assumes: registers are 12 bits wide, one aligned 32-bit word each on AXI4-Lite
// Notes: word indices are kept as printed; byte address is four times the index
// What this block does
// - write-only 12-bit autolock threshold, reset 400; zero disables, nonzero starts locking automatically.
// - general control bit 3 forces the vertical timing standard instead of detection.
// - general control bit 9 disables flywheel interlace; the control word resets to zero.
// - vertical free-run runs when force bit is one and flywheel disable bit is zero.
// - status word bit 0 vertical lock, bit 1 horizontal lock, bit 2 no signal.
// - status bits 3..6 report amplitude killer, its disable, ident killer, its disable.
// - status bit 7 interlace, bit 8 no vertical sync, bit 9 spurious vertical sync.
// - lines-per-field word reads 312 for 625-line standards and 262 for 525-line.
// - 12-bit field counter counts each field; a software write sets a new start value.
// - read-only 12-bit sync amplitude (nominal 768) and burst amplitude measurements.
// - firmware version word: revision in bits 7:0, release in bits 11:8.
// - copy-protect status: bit 0 gain-control pulses found, bit 1 pseudo sync found.
// - copy-protect window first line register, read/write, resets to line 6.
// - copy-protect window last line register, read/write, resets to line 15.
`default_nettype none
package vss_pkg;
   localparam int VSS_AW = 12;
   localparam int VSS_DW = 32;
   localparam int VSS_RW = 12;
   localparam int VSS_IW = 10;
   // register word indices
   localparam logic [9:0]  IDX_GEN_CTRL   = 10'h012;
   localparam logic [9:0]  IDX_STD_STATUS = 10'h013;
   localparam logic [9:0]  IDX_FIELD_CNT  = 10'h015;
   localparam logic [9:0]  IDX_BURST_AMP  = 10'h036;
   localparam logic [9:0]  IDX_SYNC_AMP   = 10'h074;
   localparam logic [9:0]  IDX_AUTOLOCK   = 10'h0B5;
   localparam logic [9:0]  IDX_LINES_PF   = 10'h0CB;
   localparam logic [9:0]  IDX_FW_REV     = 10'h0F0;
   localparam logic [9:0]  IDX_CP_STATUS  = 10'h170;
   localparam logic [9:0]  IDX_CP_FIRST   = 10'h171;
   localparam logic [9:0]  IDX_CP_LAST    = 10'h172;
   localparam logic [9:0]  IDX_IRQ_STATUS = 10'h180;
   localparam logic [9:0]  IDX_IRQ_MASK   = 10'h181;
   // reset values
   localparam logic [11:0] RST_AUTOLOCK   = 12'h190;
   localparam logic [11:0] RST_GEN_CTRL   = 12'h000;
   localparam logic [11:0] RST_CP_FIRST   = 12'h006;
   localparam logic [11:0] RST_CP_LAST    = 12'h00F;
   localparam logic [11:0] RST_FIELD_CNT  = 12'h000;
   localparam logic [3:0]  RST_IRQ_MASK   = 4'h0;
   // general control fields
   localparam int GC_VFORCE = 3;
   localparam int GC_DFLW   = 9;
   // standard recognition status fields
   localparam int ST_VLOCK       = 0;
   localparam int ST_HLOCK       = 1;
   localparam int ST_NO_SIGNAL   = 2;
   localparam int ST_AMP_KILL    = 3;
   localparam int ST_AMP_KILL_DIS= 4;
   localparam int ST_ID_KILL     = 5;
   localparam int ST_ID_KILL_DIS = 6;
   localparam int ST_INTERLACE   = 7;
   localparam int ST_NO_VSYNC    = 8;
   localparam int ST_SPUR_VSYNC  = 9;
   localparam int ST_W           = 10;
   // copy-protect status fields
   localparam int CP_AGC   = 0;
   localparam int CP_PSYNC = 1;
   localparam int CP_W     = 2;
   // lines per field and amplitude reference
   localparam logic [11:0] LINES_625      = 12'h138;
   localparam logic [11:0] LINES_525      = 12'h106;
   localparam logic [11:0] SYNC_AMP_NOM   = 12'h300;
   // firmware version fields
   localparam int FW_REV_LSB = 0;
   localparam int FW_REV_W   = 8;
   localparam int FW_REL_LSB = 8;
   localparam int FW_REL_W   = 4;
   // interrupt status / mask fields
   localparam int IRQ_FIELD    = 0;
   localparam int IRQ_CP       = 1;
   localparam int IRQ_STD_CHG  = 2;
   localparam int IRQ_SIG_LOST = 3;
   localparam int IRQ_W        = 4;
   // bus responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* verilog/vss_sync.sv */
// Purpose: two-stage synchroniser for a vector of front-end levels
// Assumes: each bit is a level held long against the clock period
// Notes: multi-bit words are not coherent across the crossing; see top
`timescale 1ns/1ps
`default_nettype none
module vss_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   // first stage is read only by the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule
`default_nettype wire

/* sim/vss_regs_properties.sv */
// Purpose: bus and control-output properties for vss_regs
// Assumes: one clock, synchronous active-low reset
// Notes: control outputs may only move while a write is in flight
`timescale 1ns/1ps
`default_nettype none
module vss_regs_props (
   // bus handshakes
   input wire logic        aclk, aresetn, awvalid, awready, wvalid, wready,
   input wire logic        bvalid, bready, arvalid, arready, rvalid, rready,
   input wire logic [1:0]  bresp,
   input wire logic [31:0] rdata,
   // controls
   input wire logic        autolock_enable, vertical_force, flywheel_disable,
   input wire logic        vertical_free_run, irq,
   input wire logic [11:0] autolock_threshold
);
   logic wr_pend_ff;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // open from data taken until response accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) wr_pend_ff <= 1'b0;
      else if (wvalid && wready) wr_pend_ff <= 1'b1;
      else if (bvalid && bready) wr_pend_ff <= 1'b0;
   end
   free_run_a: assert property (vertical_free_run == (vertical_force && !flywheel_disable))
      else $error("free run does not follow force and flywheel bits");
   autolock_en_a: assert property (autolock_enable == (autolock_threshold != 12'h000))
      else $error("autolock enable does not follow threshold");
   // depth two: the reset release itself loads the threshold
   // outputs lag the register by one edge, by then the response may be gone
   vforce_cause_a: assert property ($past(aresetn, 2) && $changed(vertical_force) |-> $past(wr_pend_ff))
      else $error("force bit moved without a write");
   flywheel_cause_a: assert property ($past(aresetn, 2) && $changed(flywheel_disable) |-> $past(wr_pend_ff))
      else $error("flywheel bit moved without a write");
   thresh_cause_a: assert property ($past(aresetn, 2) && $changed(autolock_threshold) |-> $past(wr_pend_ff))
      else $error("threshold moved without a write");
   wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:4] bvalid)
      else $error("write response late");
   wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   rd_answer_a: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   cover property (irq);
   cover property (bvalid && bready && bresp == 2'h2);
   cover property (vertical_free_run);
endmodule
bind vss_regs vss_regs_props u_props (.*);
`default_nettype wire

/* sim/tb_vss_regs.sv */
// Purpose: register-level test of vss_regs over AXI4-Lite
// Assumes: front-end levels are held long enough to cross the synchronisers
// Notes: masters sample at the falling edge, drive after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_vss_regs;
   import vss_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic std_525 = 0, field_toggle = 0, agc_pulse_seen = 0, pseudo_sync_seen = 0;
   logic [11:0] awaddr = 0, araddr = 0, line_number = 0, sync_amp_in = 0, burst_amp_in = 0;
   logic [31:0] wdata = 0;
   logic [9:0] std_flags = 0;
   logic [2:0] awprot = 0, arprot = 0;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, autolock_enable, vertical_force;
   logic flywheel_disable, vertical_free_run, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [11:0] autolock_threshold;
   int err_total = 0, check_count = 0;
   vss_regs #(.FW_REVISION(8'h2C), .FW_RELEASE(4'h3)) dut (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (err_total == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // address and data offered together, each released once taken
   task automatic wr(input logic [9:0] idx, input logic [11:0] d, input logic [1:0] er);
      logic a, b, da, dw, v;
      int n;
      da = 0; dw = 0; v = 0; n = 0;
      awaddr <= {idx, 2'b00}; wdata <= {20'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!v && n < 200) begin
         @(negedge aclk);
         a = awready & !da; b = wready & !dw; v = bvalid & da & dw; n++;
         if (v) chk(bresp, er);
         @(posedge aclk);
         if (a) begin awvalid <= 1'b0; da = 1; end
         if (b) begin wvalid <= 1'b0; dw = 1; end
      end
      bready <= 1'b0;
      @(posedge aclk);
      if (n >= 200) begin err_total++; tally_and_finish(); end
   endtask
   task automatic rd(input logic [9:0] idx, input logic [11:0] e, input logic [1:0] er);
      logic a, v;
      int n;
      v = 0; n = 0;
      araddr <= {idx, 2'b00}; arvalid <= 1'b1; rready <= 1'b1;
      while (!v && n < 200) begin
         @(negedge aclk);
         a = arready; v = rvalid; n++;
         if (v) begin chk(rdata, {20'h0, e}); chk(rresp, er); end
         @(posedge aclk);
         if (a) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(posedge aclk);
      if (n >= 200) begin err_total++; tally_and_finish(); end
   endtask
   // one pulse on one line, then quiet before the line moves on
   task automatic pulse(input logic [11:0] l, input logic a, input logic p);
      line_number <= l; agc_pulse_seen <= a; pseudo_sync_seen <= p; cyc(6);
      agc_pulse_seen <= 1'b0; pseudo_sync_seen <= 1'b0; cyc(4);
   endtask
   initial begin
      forever #12.5 aclk = ~aclk;
   end
   initial begin
      logic [11:0] c;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      cyc(3);
      chk(autolock_threshold, 12'd400);
      rd(IDX_GEN_CTRL, 12'h000, RESP_OKAY);
      rd(IDX_CP_FIRST, 12'd6, RESP_OKAY);
      rd(IDX_CP_LAST, 12'd15, RESP_OKAY);
      rd(IDX_LINES_PF, 12'd312, RESP_OKAY);
      wr(IDX_AUTOLOCK, 12'h000, RESP_OKAY);
      chk(autolock_enable, 1'b0);
      wr(IDX_AUTOLOCK, 12'h001, RESP_OKAY);
      chk(autolock_enable, 1'b1);
      chk(autolock_threshold, 12'h001);
      rd(IDX_AUTOLOCK, 12'h000, RESP_OKAY);
      // reserved bits are written back as read, zero since reset
      for (int i = 0; i < 4; i++) begin
         c = {2'b00, i[1], 5'h00, i[0], 3'h0};
         wr(IDX_GEN_CTRL, c, RESP_OKAY);
         rd(IDX_GEN_CTRL, c, RESP_OKAY);
         chk(vertical_force, i[0]);
         chk(flywheel_disable, i[1]);
         chk(vertical_free_run, i == 1);
      end
      for (int k = 0; k < 10; k++) begin
         std_flags <= 10'h001 << k;
         cyc(5);
         rd(IDX_STD_STATUS, 12'h001 << k, RESP_OKAY);
      end
      std_flags <= 10'h000; std_525 <= 1'b1; sync_amp_in <= 12'd768; burst_amp_in <= 12'h0A5;
      cyc(5);
      rd(IDX_LINES_PF, 12'd262, RESP_OKAY);
      rd(IDX_SYNC_AMP, 12'd768, RESP_OKAY);
      rd(IDX_BURST_AMP, 12'h0A5, RESP_OKAY);
      rd(IDX_FW_REV, 12'h32C, RESP_OKAY);
      // status changes and the no-signal rise are pending, masked
      rd(IDX_IRQ_STATUS, 12'h00C, RESP_OKAY);
      wr(IDX_FIELD_CNT, 12'hFFE, RESP_OKAY);
      field_toggle <= 1'b1; cyc(6);
      field_toggle <= 1'b0; cyc(6);
      rd(IDX_FIELD_CNT, 12'h000, RESP_OKAY);
      chk(irq, 1'b0);
      wr(IDX_IRQ_MASK, 12'h001, RESP_OKAY);
      cyc(2);
      chk(irq, 1'b1);
      rd(IDX_IRQ_STATUS, 12'h001, RESP_OKAY);
      cyc(2);
      chk(irq, 1'b0);
      pulse(12'd5, 1'b1, 1'b0);
      pulse(12'd15, 1'b0, 1'b1);
      pulse(12'd16, 1'b1, 1'b0);
      field_toggle <= 1'b1; cyc(6);
      rd(IDX_CP_STATUS, 12'h002, RESP_OKAY);
      pulse(12'd6, 1'b1, 1'b0);
      field_toggle <= 1'b0; cyc(6);
      rd(IDX_CP_STATUS, 12'h001, RESP_OKAY);
      rd(10'h100, 12'h000, RESP_SLVERR);
      wr(10'h100, 12'h5A5, RESP_SLVERR);
      tally_and_finish();
   end
endmodule
`default_nettype wire
